// ### ifp_pkg.sv
package ifp_pkg;

  // timing
  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned RES_HOLD_NS     = 100;
  localparam int unsigned RES_HOLD_CYCLES = (RES_HOLD_NS * CLK_MHZ + 999) / 1000;

  // register byte offsets
  localparam logic [7:0] OFS_EDGE_ONE   = 8'h00;
  localparam logic [7:0] OFS_EDGE_TWO   = 8'h04;
  localparam logic [7:0] OFS_EN_ONE     = 8'h08;
  localparam logic [7:0] OFS_EN_TWO     = 8'h0c;
  localparam logic [7:0] OFS_FLAG_ONE   = 8'h10;
  localparam logic [7:0] OFS_FLAG_TWO   = 8'h14;
  localparam logic [7:0] OFS_FLAG_WAKE  = 8'h18;
  localparam logic [7:0] OFS_PRIO_A     = 8'h1c;
  localparam logic [7:0] OFS_PRIO_B     = 8'h20;
  localparam logic [7:0] OFS_PRIO_C     = 8'h24;
  localparam logic [7:0] OFS_PRIO_D     = 8'h28;
  localparam logic [7:0] OFS_PIN_FUNC   = 8'h2c;
  localparam logic [7:0] OFS_SYS_CTL2   = 8'h30;
  localparam logic [7:0] OFS_STATUS     = 8'h34;

  // reset values
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [15:0] RST_PIN_FUNC  = 16'h0000;

  // reserved bits that read as one
  localparam logic [7:0] EDGE1_ONES     = 8'h70;
  localparam logic [7:0] EDGE2_ONES     = 8'hc0;
  localparam logic [7:0] EN1_ONES       = 8'h10;
  localparam logic [7:0] EN2_ONES       = 8'h1f;
  localparam logic [7:0] FLAG1_ONES     = 8'h30;
  localparam logic [7:0] FLAG2_ONES     = 8'h1f;
  localparam logic [7:0] WAKE_ONES      = 8'hc0;

  // writable masks of priority registers
  localparam logic [7:0] PRIO_A_MASK    = 8'hfe;
  localparam logic [7:0] PRIO_B_MASK    = 8'h70;
  localparam logic [7:0] PRIO_C_MASK    = 8'h97;
  localparam logic [7:0] PRIO_D_MASK    = 8'hf8;

  // field positions
  localparam int unsigned BIT_DT        = 7;
  localparam int unsigned BIT_RTC       = 6;
  localparam int unsigned BIT_WP_EN     = 5;
  localparam int unsigned BIT_TB1       = 5;
  localparam int unsigned BIT_DIRECT_TRANSITION_ON      = 0;

  // bus
  localparam logic [1:0] HTRANS_NONSEQ  = 2'b10;

  // reset vector location
  localparam logic [23:0] RESET_VEC_ADDR = 24'h000000;

  // source count
  localparam int unsigned NUM_SRC       = 20;

  typedef enum logic [2:0] {
    ST_HOLD  = 3'b000,
    ST_MASK  = 3'b001,
    ST_FETCH = 3'b011,
    ST_LOAD  = 3'b010,
    ST_RUN   = 3'b110
  } ifp_rst_state_t;

  // vector number of each source in fixed default order
  function automatic logic [5:0] src_vector(input int unsigned idx);
    logic [5:0] v;
    v = 6'h00;
    case (idx)
      0:  v = 6'd13;
      1:  v = 6'd14;
      2:  v = 6'd15;
      3:  v = 6'd16;
      4:  v = 6'd17;
      5:  v = 6'd18;
      6:  v = 6'd19;
      7:  v = 6'd22;
      8:  v = 6'd23;
      9:  v = 6'd24;
      10: v = 6'd29;
      11: v = 6'd32;
      12: v = 6'd34;
      13: v = 6'd35;
      14: v = 6'd36;
      15: v = 6'd37;
      16: v = 6'd38;
      17: v = 6'd39;
      18: v = 6'd40;
      19: v = 6'd41;
      default: v = 6'h00;
    endcase
    return v;
  endfunction : src_vector

endpackage : ifp_pkg

// ### ifp_ctrl.sv
`timescale 1ns/100ps
// Overview of operation
// - timer B1 request reaches CPU only when enable bit 5 is one
// - reserved bits 4..0 of enable two, flags two, 5..4 of flags one read one
// - request coinciding with a clear is kept and still handled
// - direct transition flag sets on sleep transition when transition-on bit is one
// - RTC flag sets on each RTC counter overflow
// - external pin flag sets on chosen edge when pin selected as interrupt
// - timer B1 flag sets on timer B1 counter overflow
// - reserved bits 7..6 of flags two read zero
// - wakeup pin flag sets on chosen edge when pin selected as interrupt
// - priority bit zero gives level zero, one gives level one
// - priority A and B bit mapping per source
// - priority C and D bit mapping per source
// - priority bits reset to zero, reserved priority bits read zero
// - while reset pin low, processing halts and registers initialise
// - after valid release, first set the CPU interrupt mask bit
// - then fetch reset vector at 0..3, load program counter, run
// - edge select zero means falling edge, one means rising edge
// - level one requests win, ties broken by default vector order
module ifp_ctrl
  import ifp_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = RES_HOLD_CYCLES
) (
  input  wire logic        mclk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        reset_in_n,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hwdata_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic [3:0]  ext_interrupt_pins_in,
  input  wire logic [5:0]  wakeup_pins_in,
  input  wire logic        rtc_overflow_in,
  input  wire logic        timer_b1_overflow_in,
  input  wire logic        sleep_direct_in,
  input  wire logic [11:0] periph_req_in,
  output logic             irq_req_out,
  output logic      [5:0]  irq_vector_out,
  output logic             irq_level_out,
  output logic             cpu_halt_out,
  output logic             mask_set_out,
  output logic             vec_fetch_out,
  output logic      [23:0] vec_addr_out,
  input  wire logic        vec_valid_in,
  input  wire logic [31:0] vec_data_in,
  output logic             pc_load_out,
  output logic      [23:0] pc_value_out
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  ifp_rst_state_t     state_reg;
  ifp_rst_state_t     state_next;
  logic [2:0]         res_sync_reg;
  logic [15:0]        hold_cnt_reg;
  logic               blk_rst;

  logic [9:0]         pin_s1_reg;
  logic [9:0]         pin_s2_reg;
  logic [9:0]         pin_s3_reg;
  logic [9:0]         pin_stable_reg;
  logic [9:0]         pin_edge;

  logic [7:0]         edge_one_reg;
  logic [7:0]         edge_two_reg;
  logic [7:0]         en_one_reg;
  logic [7:0]         en_two_reg;
  logic [7:0]         flag_one_reg;
  logic [7:0]         flag_two_reg;
  logic [7:0]         wake_flag_reg;
  logic [7:0]         prio_a_reg;
  logic [7:0]         prio_b_reg;
  logic [7:0]         prio_c_reg;
  logic [7:0]         prio_d_reg;
  logic [15:0]        pin_func_reg;
  logic [7:0]         sys_ctl2_reg;

  logic               wr_pend_reg;
  logic [7:0]         wr_addr_reg;
  logic [7:0]         wdata;
  logic [31:0]        rd_value;

  logic [NUM_SRC-1:0] src_req;
  logic [NUM_SRC-1:0] src_lvl;
  logic               any_hi;
  logic               win_found;
  logic [5:0]         win_vec;
  logic               win_lvl;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic wr_hit(input logic pend, input logic [7:0] a,
                                  input logic [7:0] ofs);
    return pend && (a == ofs);
  endfunction : wr_hit

  // hardware set wins over a software clear; writing one keeps the bit
  function automatic logic [7:0] flag_upd(input logic [7:0] cur, input logic hit,
                                          input logic [7:0] wd, input logic [7:0] set);
    logic [7:0] keep;
    keep = hit ? (cur & wd) : cur;
    return keep | set;
  endfunction : flag_upd

  ////////////////////////////////////////////////////////////////////////////
  // reset pin and reset exception sequence

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      res_sync_reg <= 3'b000;
    end else begin
      res_sync_reg <= {res_sync_reg[1:0], reset_in_n};
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || state_reg != ST_HOLD) begin
      hold_cnt_reg <= 16'h0000;
    end else if (hold_cnt_reg < HOLD_CYCLES[15:0]) begin
      hold_cnt_reg <= hold_cnt_reg + 16'h0001;
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_HOLD: begin
        if (res_sync_reg[1] && res_sync_reg[2] && hold_cnt_reg >= HOLD_CYCLES[15:0]) begin
          state_next = ST_MASK;
        end
      end
      ST_MASK:  state_next = ST_FETCH;
      ST_FETCH: begin
        if (vec_valid_in) begin
          state_next = ST_LOAD;
        end
      end
      ST_LOAD:  state_next = ST_RUN;
      ST_RUN:   state_next = ST_RUN;
    endcase
    if (!res_sync_reg[1] && !res_sync_reg[2]) begin
      state_next = ST_HOLD;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      state_reg <= ST_HOLD;
    end else begin
      state_reg <= state_next;
    end
  end

  // pin reset initialises the control, priority, flag and request registers of the block
  assign blk_rst = sys_rst_in || (state_reg == ST_HOLD);

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pc_value_out <= 24'h000000;
    end else if (state_reg == ST_FETCH && vec_valid_in) begin
      pc_value_out <= vec_data_in[23:0];
    end
  end

  assign cpu_halt_out  = (state_reg != ST_RUN);
  assign mask_set_out  = (state_reg == ST_MASK);
  assign vec_fetch_out = (state_reg == ST_FETCH);
  assign vec_addr_out  = RESET_VEC_ADDR;
  assign pc_load_out   = (state_reg == ST_LOAD);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pin_s1_reg     <= 10'h3ff;
      pin_s2_reg     <= 10'h3ff;
      pin_s3_reg     <= 10'h3ff;
      pin_stable_reg <= 10'h3ff;
    end else begin
      pin_s1_reg <= {wakeup_pins_in, ext_interrupt_pins_in};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      for (int i = 0; i < 10; i++) begin
        if (pin_s2_reg[i] == pin_s3_reg[i]) begin
          pin_stable_reg[i] <= pin_s3_reg[i];
        end
      end
    end
  end

  always_comb begin
    logic [9:0] sel_edge;
    logic [9:0] sel_func;
    sel_edge = {edge_two_reg[5:0], edge_one_reg[3:0]};
    sel_func = {pin_func_reg[13:8], pin_func_reg[3:0]};
    for (int i = 0; i < 10; i++) begin
      pin_edge[i] = sel_func[i] && (pin_s2_reg[i] == pin_s3_reg[i]) &&
                    (pin_s3_reg[i] != pin_stable_reg[i]) &&
                    (pin_s3_reg[i] == sel_edge[i]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else if (hready_in) begin
      wr_pend_reg <= hsel_in && htrans_in == HTRANS_NONSEQ && hwrite_in;
      wr_addr_reg <= haddr_in[7:0];
    end
  end

  assign wdata = hwdata_in[7:0];

  always_comb begin
    unique case (haddr_in[7:0])
      OFS_EDGE_ONE:  rd_value = {24'h000000, edge_one_reg | EDGE1_ONES};
      OFS_EDGE_TWO:  rd_value = {24'h000000, edge_two_reg | EDGE2_ONES};
      OFS_EN_ONE:    rd_value = {24'h000000, en_one_reg | EN1_ONES};
      OFS_EN_TWO:    rd_value = {24'h000000, en_two_reg | EN2_ONES};
      OFS_FLAG_ONE:  rd_value = {24'h000000, flag_one_reg | FLAG1_ONES};
      OFS_FLAG_TWO:  rd_value = {24'h000000, flag_two_reg | FLAG2_ONES};
      OFS_FLAG_WAKE: rd_value = {24'h000000, wake_flag_reg | WAKE_ONES};
      OFS_PRIO_A:    rd_value = {24'h000000, prio_a_reg};
      OFS_PRIO_B:    rd_value = {24'h000000, prio_b_reg};
      OFS_PRIO_C:    rd_value = {24'h000000, prio_c_reg};
      OFS_PRIO_D:    rd_value = {24'h000000, prio_d_reg};
      OFS_PIN_FUNC:  rd_value = {16'h0000, pin_func_reg};
      OFS_SYS_CTL2:  rd_value = {24'h000000, sys_ctl2_reg};
      OFS_STATUS:    rd_value = {16'h0000, 5'h00, state_reg, irq_req_out,
                                 irq_level_out, irq_vector_out};
      default:       rd_value = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      hrdata_out <= 32'h00000000;
    end else if (hready_in && hsel_in && htrans_in == HTRANS_NONSEQ && !hwrite_in) begin
      hrdata_out <= rd_value;
    end
  end

  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  always_ff @(posedge mclk_in) begin
    if (blk_rst) begin
      edge_one_reg <= RST_BYTE;
      edge_two_reg <= RST_BYTE;
      en_one_reg   <= RST_BYTE;
      en_two_reg   <= RST_BYTE;
      pin_func_reg <= RST_PIN_FUNC;
      sys_ctl2_reg <= RST_BYTE;
    end else begin
      if (wr_hit(wr_pend_reg, wr_addr_reg, OFS_EDGE_ONE)) begin
        edge_one_reg <= wdata & 8'h8f;
      end
      if (wr_hit(wr_pend_reg, wr_addr_reg, OFS_EDGE_TWO)) begin
        edge_two_reg <= wdata & 8'h3f;
      end
      if (wr_hit(wr_pend_reg, wr_addr_reg, OFS_EN_ONE)) begin
        en_one_reg <= wdata & 8'hef;
      end
      if (wr_hit(wr_pend_reg, wr_addr_reg, OFS_EN_TWO)) begin
        en_two_reg <= wdata & 8'h20;
      end
      if (wr_hit(wr_pend_reg, wr_addr_reg, OFS_PIN_FUNC)) begin
        pin_func_reg <= hwdata_in[15:0] & 16'h3f0f;
      end
      if (wr_hit(wr_pend_reg, wr_addr_reg, OFS_SYS_CTL2)) begin
        sys_ctl2_reg <= wdata & 8'h01;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (blk_rst) begin
      prio_a_reg <= RST_BYTE;
      prio_b_reg <= RST_BYTE;
      prio_c_reg <= RST_BYTE;
      prio_d_reg <= RST_BYTE;
    end else begin
      if (wr_hit(wr_pend_reg, wr_addr_reg, OFS_PRIO_A)) begin
        prio_a_reg <= wdata & PRIO_A_MASK;
      end
      if (wr_hit(wr_pend_reg, wr_addr_reg, OFS_PRIO_B)) begin
        prio_b_reg <= wdata & PRIO_B_MASK;
      end
      if (wr_hit(wr_pend_reg, wr_addr_reg, OFS_PRIO_C)) begin
        prio_c_reg <= wdata & PRIO_C_MASK;
      end
      if (wr_hit(wr_pend_reg, wr_addr_reg, OFS_PRIO_D)) begin
        prio_d_reg <= wdata & PRIO_D_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request flags

  always_ff @(posedge mclk_in) begin
    logic [7:0] set1;
    logic [7:0] set2;
    logic [7:0] setw;
    set1 = 8'h00;
    set2 = 8'h00;
    setw = 8'h00;
    set1[BIT_DT]  = sleep_direct_in && sys_ctl2_reg[BIT_DIRECT_TRANSITION_ON];
    set1[BIT_RTC] = rtc_overflow_in;
    set1[3:0]     = pin_edge[3:0];
    set2[BIT_TB1] = timer_b1_overflow_in;
    setw[5:0]     = pin_edge[9:4];
    if (blk_rst) begin
      flag_one_reg  <= RST_BYTE;
      flag_two_reg  <= RST_BYTE;
      wake_flag_reg <= RST_BYTE;
    end else begin
      flag_one_reg  <= flag_upd(flag_one_reg,
                                wr_hit(wr_pend_reg, wr_addr_reg, OFS_FLAG_ONE),
                                wdata, set1) & 8'hcf;
      flag_two_reg  <= flag_upd(flag_two_reg,
                                wr_hit(wr_pend_reg, wr_addr_reg, OFS_FLAG_TWO),
                                wdata, set2) & 8'h20;
      wake_flag_reg <= flag_upd(wake_flag_reg,
                                wr_hit(wr_pend_reg, wr_addr_reg, OFS_FLAG_WAKE),
                                wdata, setw) & 8'h3f;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source requests, levels and arbitration

  always_comb begin
    src_req[0]     = flag_one_reg[BIT_DT] && en_one_reg[BIT_DT];
    src_req[4:1]   = flag_one_reg[3:0] & en_one_reg[3:0];
    src_req[5]     = (|wake_flag_reg[5:0]) && en_one_reg[BIT_WP_EN];
    src_req[6]     = flag_one_reg[BIT_RTC] && en_one_reg[BIT_RTC];
    src_req[9:7]   = periph_req_in[2:0];
    src_req[10]    = flag_two_reg[BIT_TB1] && en_two_reg[BIT_TB1];
    src_req[19:11] = periph_req_in[11:3];
  end

  always_comb begin
    src_lvl[0]     = prio_a_reg[7];
    src_lvl[1]     = prio_a_reg[6];
    src_lvl[4:2]   = {prio_a_reg[3], prio_a_reg[4], prio_a_reg[5]};
    src_lvl[5]     = prio_a_reg[2];
    src_lvl[6]     = prio_a_reg[1];
    src_lvl[9:7]   = {prio_b_reg[4], prio_b_reg[5], prio_b_reg[6]};
    src_lvl[10]    = prio_c_reg[7];
    src_lvl[11]    = prio_c_reg[4];
    src_lvl[12]    = prio_c_reg[2];
    src_lvl[13]    = prio_c_reg[1];
    src_lvl[14]    = prio_c_reg[0];
    src_lvl[18:15] = {prio_d_reg[4], prio_d_reg[5], prio_d_reg[6], prio_d_reg[7]};
    src_lvl[19]    = prio_d_reg[3];
  end

  always_comb begin
    any_hi    = |(src_req & src_lvl);
    win_found = 1'b0;
    win_vec   = 6'h00;
    win_lvl   = 1'b0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (src_req[i] && (src_lvl[i] == any_hi)) begin
        win_found = 1'b1;
        win_vec   = src_vector(i);
        win_lvl   = src_lvl[i];
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (blk_rst) begin
      irq_req_out    <= 1'b0;
      irq_vector_out <= 6'h00;
      irq_level_out  <= 1'b0;
    end else begin
      irq_req_out    <= win_found;
      irq_vector_out <= win_vec;
      irq_level_out  <= win_lvl;
    end
  end

endmodule : ifp_ctrl

// ### ifp_ctrl_properties.sv
`timescale 1ns/100ps
module ifp_ctrl_properties
  import ifp_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = RES_HOLD_CYCLES
) (
  input wire logic        mclk_in,
  input wire logic        sys_rst_in,
  input wire logic        reset_in_n,
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic        hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic        cpu_halt_out,
  input wire logic        mask_set_out,
  input wire logic        vec_fetch_out,
  input wire logic [23:0] vec_addr_out,
  input wire logic        vec_valid_in,
  input wire logic [31:0] vec_data_in,
  input wire logic        pc_load_out,
  input wire logic [23:0] pc_value_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  ////////////////////////////////////////
  sequence rd_s(logic [7:0] a);
    hsel_in && hready_in && htrans_in == HTRANS_NONSEQ && !hwrite_in && !cpu_halt_out &&
      haddr_in[7:0] == a;
  endsequence
  a_flag2_rsv: assert property (
    rd_s(OFS_FLAG_TWO) |=> (hrdata_out & 32'hffffffdf) == 32'h1f)
    else $error("flags two reserved bits wrong");
  a_en2_rsv: assert property (
    rd_s(OFS_EN_TWO) |=> (hrdata_out & 32'hffffffdf) == 32'h1f)
    else $error("enable two reserved bits wrong");
  a_flag1_rsv: assert property (
    rd_s(OFS_FLAG_ONE) |=> (hrdata_out & 32'hffffff30) == 32'h30)
    else $error("flags one reserved bits wrong");
  a_prio_rsv: assert property (
    rd_s(OFS_PRIO_B) |=> (hrdata_out[7:0] & ~PRIO_B_MASK) == 8'h00)
    else $error("priority reserved bits not zero");
  a_halt_on_pin: assert property (
    !reset_in_n [*6] |-> cpu_halt_out)
    else $error("no halt while reset pin low");
  a_mask_first: assert property (
    $rose(vec_fetch_out) |-> $past(mask_set_out))
    else $error("vector fetch without mask set");
  a_mask_then_fetch: assert property (
    mask_set_out |=> vec_fetch_out && !mask_set_out)
    else $error("mask set not followed by fetch");
  a_vec_addr: assert property (
    vec_fetch_out |-> vec_addr_out == RESET_VEC_ADDR)
    else $error("wrong vector address");
  a_pc_load: assert property (
    vec_fetch_out && vec_valid_in |=>
      pc_load_out && {8'h00, pc_value_out} == ($past(vec_data_in) & 32'h00ffffff))
    else $error("program counter load wrong");
  a_run_after: assert property (
    pc_load_out |=> !cpu_halt_out)
    else $error("no run after load");
  cover property (pc_load_out);
  cover property (mask_set_out);
  cover property (rd_s(OFS_FLAG_TWO));
endmodule : ifp_ctrl_properties

bind ifp_ctrl ifp_ctrl_properties #(.HOLD_CYCLES(HOLD_CYCLES)) ifp_ctrl_properties_inst (
  .mclk_in, .sys_rst_in, .reset_in_n, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
  .hready_in, .hrdata_out, .cpu_halt_out, .mask_set_out, .vec_fetch_out, .vec_addr_out,
  .vec_valid_in, .vec_data_in, .pc_load_out, .pc_value_out
);

// ### ifp_cpu_model.sv
`timescale 1ns/100ps
module ifp_cpu_model (
  input  wire logic        clk_in,
  input  wire logic        fetch_in,
  input  wire logic [23:0] addr_in,
  input  wire logic [31:0] word_in,
  input  wire logic [2:0]  wait_in,
  output logic             valid_out,
  output logic      [31:0] data_out
);
  logic [3:0] cnt_reg;
  // answer the vector read after wait_in cycles, a moving pattern otherwise
  always_ff @(posedge clk_in) begin
    cnt_reg   <= fetch_in ? cnt_reg + 4'h1 : 4'h0;
    valid_out <= fetch_in && cnt_reg == {1'b0, wait_in};
    data_out  <= (fetch_in && cnt_reg == {1'b0, wait_in} && addr_in == 24'h0) ?
                 word_in : {8{~cnt_reg}};
  end
endmodule : ifp_cpu_model

// ### tb_ifp_ctrl.sv
`timescale 1ns/100ps
module tb_ifp_ctrl
  import ifp_pkg::*;
();
  logic        clk = 1'b0, rst = 1'b1, pin_n = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic        rtc = 1'b0, tb1 = 1'b0, slp = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, pword = 32'h0, rnd = 32'h0dd9;
  logic [1:0]  htrans = 2'b00;
  logic [3:0]  ext = 4'hf;
  logic [5:0]  wak = 6'h3f;
  logic [2:0]  pwait = 3'h0;
  logic [31:0] hrdata, vdata;
  logic        hrdy, hresp, irq, lvl, halt, vvalid, vfetch;
  logic [11:0] preq = 12'h000;
  logic [5:0]  vec;
  logic [23:0] vaddr, pcv;
  logic [7:0]  ra [9] = '{OFS_EN_TWO, OFS_FLAG_ONE, OFS_FLAG_TWO, OFS_FLAG_WAKE, OFS_PRIO_A,
                          OFS_PRIO_B, OFS_PRIO_C, OFS_PRIO_D, 8'h3c};
  // peripheral request slot: priority word index in high nibble, bit below
  logic [7:0]  pmap [12] = '{8'h86, 8'h85, 8'h84, 8'h94, 8'h92, 8'h91, 8'h90, 8'ha7, 8'ha6,
                             8'ha5, 8'ha4, 8'ha3};
  logic [5:0]  pvec [12] = '{6'd22, 6'd23, 6'd24, 6'd32, 6'd34, 6'd35, 6'd36, 6'd37, 6'd38,
                             6'd39, 6'd40, 6'd41};
  int          m [16], k [16];
  int          fail_count = 0, compares = 0;

  ifp_ctrl #(.HOLD_CYCLES(2)) ifp_ctrl_inst (
    .mclk_in(clk), .sys_rst_in(rst), .reset_in_n(pin_n), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010), .hready_in(hrdy),
    .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
    .ext_interrupt_pins_in(ext), .wakeup_pins_in(wak), .rtc_overflow_in(rtc),
    .timer_b1_overflow_in(tb1), .sleep_direct_in(slp), .periph_req_in(preq),
    .irq_req_out(irq), .irq_vector_out(vec), .irq_level_out(lvl), .cpu_halt_out(halt),
    .mask_set_out(), .vec_fetch_out(vfetch), .vec_addr_out(vaddr), .vec_valid_in(vvalid),
    .vec_data_in(vdata), .pc_load_out(), .pc_value_out(pcv)
  );
  ifp_cpu_model ifp_cpu_model_inst (
    .clk_in(clk), .fetch_in(vfetch), .addr_in(vaddr), .word_in(pword), .wait_in(pwait),
    .valid_out(vvalid), .data_out(vdata)
  );

  always #2 clk = ~clk;
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic plvl(input int q);
    return m[pmap[q][7:4]][pmap[q][2:0]];
  endfunction : plvl

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    if (fail_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  task automatic mreset();
    k = '{3: 8'h1f, 4: 8'h30, 5: 8'h1f, 6: 8'hc0, default: 0};
    m = k;
  endtask : mreset

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ev);
    int i;
    i = a >> 2;
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= 1'b1;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'b00;
    hwrite <= 1'b0;
    hwdata <= d;
    tb1    <= ev;
    do @(posedge clk); while (hrdy !== 1'b1);
    tb1 <= 1'b0;
    case (a)
      OFS_FLAG_ONE, OFS_FLAG_TWO, OFS_FLAG_WAKE: m[i] = (m[i] & d) | k[i] | {ev, 5'h0};
      OFS_EN_TWO: m[i] = (d & 32'h20) | k[i];
      OFS_PRIO_A: m[i] = d & PRIO_A_MASK;
      OFS_PRIO_B: m[i] = d & PRIO_B_MASK;
      OFS_PRIO_C: m[i] = d & PRIO_C_MASK;
      OFS_PRIO_D: m[i] = d & PRIO_D_MASK;
      default: m[i] = d;
    endcase
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= 1'b0;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'b00;
    do @(posedge clk); while (hrdy !== 1'b1);
    chk(hrdata, m[a >> 2]);
    chk({31'h0, hresp}, 32'h0);
  endtask : rd

  task automatic pulse(input int s);
    @(posedge clk);
    if (s == 0) slp <= 1'b1;
    else if (s == 1) rtc <= 1'b1;
    else tb1 <= 1'b1;
    @(posedge clk);
    {slp, rtc, tb1} <= 3'b000;
    m[4] = m[4] | (s == 0 && m[12][0] ? 8'h80 : s == 1 ? 8'h40 : 8'h00);
    m[5] = m[5] | (s == 2 ? 8'h20 : 8'h00);
    repeat (2) @(posedge clk);
  endtask : pulse

  // model arbitration over direct transition, clock overflow and timer sources
  task automatic irqchk();
    logic [7:0] b;
    logic [2:0] p, l;
    logic [5:0] v [3];
    b = 8'h00;
    v = '{6'd13, 6'd19, 6'd29};
    p = {m[5][5] & m[3][5], m[4][6] & m[2][6], m[4][7] & m[2][7]};
    l = {m[9][7], m[7][1], m[7][7]};
    for (int i = 2; i >= 0; i--)
      if (p[i] && (!b[7] || l[i] >= b[6])) b = {1'b1, l[i], v[i]};
    repeat (3) @(posedge clk);
    @(negedge clk);
    if (b[7]) chk({24'h0, irq, lvl, vec}, {24'h0, b});
    else chk({31'h0, irq}, 32'h0);
  endtask : irqchk

  task automatic pins(input logic e);
    logic [3:0] x;
    logic [5:0] w;
    rnd = lfsr(rnd);
    x = ext ^ rnd[3:0];
    w = wak ^ rnd[13:8];
    @(posedge clk);
    ext <= x;
    wak <= w;
    repeat (8) @(posedge clk);
    m[4] = m[4] | (rnd[3:0] & (e ? x : ~x));
    m[6] = m[6] | (rnd[13:8] & (e ? w : ~w));
    rd(OFS_FLAG_ONE);
    rd(OFS_FLAG_WAKE);
  endtask : pins

  task automatic boot();
    rnd = lfsr(rnd);
    pword <= rnd;
    pwait <= rnd[2:0];
    for (int n = 0; n < 300 && ifp_ctrl_inst.pc_load_out !== 1'b1; n++) @(posedge clk);
    @(negedge clk);
    chk({8'h0, pcv}, {8'h0, rnd[23:0]});
    chk({31'h0, halt}, 32'h0);
  endtask : boot
  ////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_of_test();
  end

  initial begin
    mreset();
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    boot();
    foreach (ra[i]) rd(ra[i]);
    for (int j = 0; j < 8; j++) begin
      rnd = lfsr(rnd);
      wr(ra[4 + j % 4], rnd, 1'b0);
      rd(ra[4 + j % 4]);
    end
    wr(OFS_SYS_CTL2, 32'h0, 1'b0);
    pulse(0);
    rd(OFS_FLAG_ONE);
    wr(OFS_SYS_CTL2, 32'h1, 1'b0);
    for (int s = 0; s < 3; s++) pulse(s);
    rd(OFS_FLAG_ONE);
    rd(OFS_FLAG_TWO);
    irqchk();
    wr(OFS_FLAG_ONE, 32'hff, 1'b0);
    rd(OFS_FLAG_ONE);
    wr(OFS_FLAG_ONE, 32'h7f, 1'b0);
    rd(OFS_FLAG_ONE);
    wr(OFS_EN_ONE, 32'hc0, 1'b0);
    irqchk();
    wr(OFS_EN_TWO, 32'h20, 1'b0);
    irqchk();
    wr(OFS_PRIO_C, 32'h80, 1'b0);
    irqchk();
    wr(OFS_PRIO_A, 32'h02, 1'b0);
    irqchk();
    wr(OFS_FLAG_TWO, 32'h0, 1'b1);
    rd(OFS_FLAG_TWO);
    irqchk();
    wr(OFS_FLAG_TWO, 32'h0, 1'b0);
    rd(OFS_FLAG_TWO);
    wr(OFS_PIN_FUNC, 32'h3f0f, 1'b0);
    for (int e = 0; e < 2; e++) begin
      wr(OFS_EDGE_ONE, {28'h0, {4{e[0]}}}, 1'b0);
      wr(OFS_EDGE_TWO, {26'h0, {6{e[0]}}}, 1'b0);
      wr(OFS_FLAG_ONE, 32'h0, 1'b0);
      wr(OFS_FLAG_WAKE, 32'h0, 1'b0);
      repeat (3) pins(e[0]);
    end
    @(posedge clk);
    pin_n <= 1'b0;
    repeat (10) @(posedge clk);
    pin_n <= 1'b1;
    @(negedge clk);
    chk({31'h0, halt}, 32'h1);
    mreset();
    boot();
    foreach (ra[i]) rd(ra[i]);
    for (int j = 5; j < 8; j++) begin
      rnd = lfsr(rnd);
      wr(ra[j], rnd, 1'b0);
    end
    for (int q = 0; q < 12; q++) begin
      int r, w;
      r = (q + 5) % 12;
      w = (plvl(r) > plvl(q) || (plvl(r) == plvl(q) && r < q)) ? r : q;
      @(posedge clk);
      preq <= (12'h001 << q) | (12'h001 << r);
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk({24'h0, irq, lvl, vec}, {24'h0, 1'b1, plvl(w), pvec[w]});
    end
    end_of_test();
  end
endmodule : tb_ifp_ctrl
